// *** dv/ext_osc_model.sv ***
// Purpose: external crystal driving the block's oscillator input
// Assumes: run high means the crystal oscillates
// Notes:   a dead crystal freezes at its last level
`timescale 1ns/10ps
module ext_osc_model #(
    parameter realtime HALF = 20.0   // half period in ns
) (
    input  wire logic run,   // oscillate when high
    output logic      osc    // oscillator level
);
    // toggle while running; edges never meet a rising clock edge
    initial
    begin
        osc = 1'b0;
        forever
        begin
            #(HALF);
            if (run)
                osc = ~osc;
        end
    end
endmodule : ext_osc_model

// *** dv/test_two_speed_failsafe_clock_ctrl.sv ***
// Purpose: register and clock sequencing test of the clock control block
// Assumes: short startup and divider counts keep the run brief
// Notes:   internal oscillators come from simple toggling processes
`timescale 1ns/10ps
module test_two_speed_failsafe_clock_ctrl;
    logic        clock, arst_n, cyc, stb, we, ack;   // bus and clock
    logic [3:0]  adr, sel, freqSel;                  // address, enables
    logic [31:0] datI, datO, rdat;                   // data
    logic        extOsc, internal_osc_block, slowOsc, t1Osc, extRun;  // oscillators
    logic [2:0]  oscMode;                            // config mode
    logic        monEn, sysClk, config_pll_force, failIrq;      // misc
    logic [6:0]  stat;                               // status inputs
    logic [1:0]  activeSrc;                          // active source
    logic [5:0]  trim;                               // trim out
    int          mismatches, n_tests;                // score
    two_speed_failsafe_clock_ctrl #(.OST_COUNT(8), .DIV_COUNT(8)) u_dut (
        .clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
        .extOsc(extOsc), .internal_osc_block(internal_osc_block), .slowOsc(slowOsc), .timer1Osc(t1Osc),
        .configOscMode(oscMode), .twoSpeedEnable(1'b1), .failMonEnable(monEn),
        .configPllForce(monEn), .sleepReq(1'b0), .wakeReq(1'b0), .timer1Ready(stat[6]),
        .pllReady(stat[5]), .fastReady(stat[4]), .fastLocked(stat[3]), .fastStable(stat[0]),
        .midReady(stat[2]), .slowReady(stat[1]), .sysClk(sysClk), .activeSrc(activeSrc),
        .intFreqSel(freqSel), .freqTrim(trim), .pllEnable(config_pll_force), .failIrq(failIrq));
    ext_osc_model u_xtal (.run(extRun), .osc(extOsc));
    // clocks: internal oscillators never edge on a rising clock edge
    always #2.5 clock = ~clock;
    always #10 internal_osc_block = ~internal_osc_block;
    always #10 slowOsc = ~slowOsc;
    always #30 t1Osc = ~t1Osc;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; held until ack is sampled, bounded wait
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clock);
        {cyc, stb, we, adr, datI, sel} <= {2'b11, w, a, d, s};
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        chk({31'h0, ack}, 32'h1);
        rdat = datO;
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(rdat, exp);
    endtask : rd
    task automatic waitSrc(input logic [1:0] v, input int lim);
        int n = 0;
        while (activeSrc !== v && n < lim)
        begin
            @(posedge clock);
            n++;
        end
        chk({30'h0, activeSrc}, {30'h0, v});
    endtask : waitSrc
    task automatic doReset();
        arst_n <= 1'b0;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
    endtask : doReset
    task automatic results();
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    // watchdog: the sequence needs well under two thousand cycles
    initial
    begin
        #100000;
        mismatches++;
        results();
    end
    // main sequence
    initial
    begin
        {clock, internal_osc_block, slowOsc, t1Osc, cyc, stb, we} = 7'h00;
        {adr, sel, datI, mismatches, n_tests} = '0;
        {arst_n, extRun, monEn, oscMode, stat} = {3'b111, clk_ctrl_pkg::MODE_XT, 7'b0101100};
        doReset();
        chk({30'h0, activeSrc}, 32'h2);
        chk({31'h0, config_pll_force}, 32'h1);
        rd(clk_ctrl_pkg::OFS_CONTROL, 32'h38);
        rd(clk_ctrl_pkg::OFS_STATUS, 32'hCC);
        rd(4'h6, 32'h0);
        bus(1'b1, clk_ctrl_pkg::OFS_TRIM, 32'hFFFFFFFF, 4'hF);
        bus(1'b1, clk_ctrl_pkg::OFS_TRIM, 32'h0, 4'hE);
        rd(clk_ctrl_pkg::OFS_TRIM, 32'h3F);
        bus(1'b1, clk_ctrl_pkg::OFS_CONTROL, 32'h54, 4'hF);
        bus(1'b1, clk_ctrl_pkg::OFS_STATUS, 32'h0, 4'hF);
        waitSrc(2'h0, 400);
        rd(clk_ctrl_pkg::OFS_STATUS, 32'hEC);
        rd(clk_ctrl_pkg::OFS_CONTROL, 32'h50);
        extRun <= 1'b0;
        waitSrc(2'h2, 200);
        chk({28'h0, freqSel}, 32'hA);
        rd(clk_ctrl_pkg::OFS_FLAGS, 32'h5);
        bus(1'b1, clk_ctrl_pkg::OFS_FLAGS, 32'h2, 4'hF);
        rd(clk_ctrl_pkg::OFS_FLAGS, 32'h7);
        chk({31'h0, failIrq}, 32'h1);
        rd(clk_ctrl_pkg::OFS_STATUS, 32'hCC);
        rd(clk_ctrl_pkg::OFS_CONTROL, 32'h50);
        extRun <= 1'b1;
        bus(1'b1, clk_ctrl_pkg::OFS_CONTROL, 32'h51, 4'hF);
        waitSrc(2'h1, 100);
        bus(1'b1, clk_ctrl_pkg::OFS_CONTROL, 32'h50, 4'hF);
        waitSrc(2'h0, 400);
        bus(1'b1, clk_ctrl_pkg::OFS_FLAGS, 32'hA, 4'hF);
        rd(clk_ctrl_pkg::OFS_FLAGS, 32'hA);
        chk({31'h0, failIrq}, 32'h0);
        stat <= 7'b0010011;
        rd(clk_ctrl_pkg::OFS_STATUS, 32'h33);
        {oscMode, monEn} <= {3'h4, 1'b0};
        doReset();
        waitSrc(2'h0, 40);
        rd(clk_ctrl_pkg::OFS_CONTROL, 32'h38);
        extRun <= 1'b0;
        repeat (300) @(posedge clock);
        chk({30'h0, activeSrc}, 32'h0);
        rd(clk_ctrl_pkg::OFS_FLAGS, 32'h0);
        results();
    end
endmodule : test_two_speed_failsafe_clock_ctrl

// *** dv/two_speed_failsafe_clock_ctrl_properties.sv ***
// Purpose: port-level timing checks for the clock control block
// Assumes: single clock domain, bound to every instance of the block
// Notes:   stall bound covers a sample period plus synchroniser delay
`timescale 1ns/10ps
module two_speed_failsafe_clock_ctrl_properties #(
    parameter int OST_COUNT = 1024,   // startup count
    parameter int DIV_COUNT = 64      // sample divider
) (
    input wire logic        clock,          // system clock
    input wire logic        arst_n,         // async reset
    input wire logic        wb_cyc_i,       // bus cycle
    input wire logic        wb_stb_i,       // bus strobe
    input wire logic        wb_we_i,        // bus write
    input wire logic [3:0]  wb_adr_i,       // bus address
    input wire logic [3:0]  wb_sel_i,       // byte enables
    input wire logic [31:0] wb_dat_i,       // write data
    input wire logic [31:0] wb_dat_o,       // read data
    input wire logic        wb_ack_o,       // bus ack
    input wire logic        extOsc,         // external osc
    input wire logic [2:0]  configOscMode,  // osc mode
    input wire logic        failMonEnable,  // monitor enable
    input wire logic        sleepReq,       // sleep pulse
    input wire logic        wakeReq,        // wake pulse
    input wire logic        sysClk,         // system clock out
    input wire logic [1:0]  activeSrc,      // active source
    input wire logic [3:0]  intFreqSel,     // freq select out
    input wire logic [5:0]  freqTrim        // trim out
);
    localparam int STALL_MAX = 150;   // generous: sample period is far shorter
    logic [7:0]  stallCnt_r;          // cycles since ext level change
    logic [11:0] extCnt_r;            // ext rising edges since start
    logic        extOld_r;            // previous ext level
    logic        asleep_r;            // between sleep and wake
    // watch the external oscillator for activity
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stallCnt_r <= 8'h00;
            extCnt_r   <= 12'h000;
            extOld_r   <= 1'b0;
            asleep_r   <= 1'b0;
        end
        else
        begin
            extOld_r <= extOsc;
            if (extOsc != extOld_r)
                stallCnt_r <= 8'h00;
            else if (stallCnt_r != 8'hFF)
                stallCnt_r <= stallCnt_r + 8'h01;
            if (sleepReq || wakeReq)   // startup count restarts on wake
                extCnt_r <= 12'h000;
            else if (extOsc && !extOld_r && extCnt_r != 12'hFFF)
                extCnt_r <= extCnt_r + 12'h001;
            if (sleepReq)
                asleep_r <= 1'b1;
            else if (wakeReq)
                asleep_r <= 1'b0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    property p_ackOnce;
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_ackCause;
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    property p_hiZero;
        (wb_ack_o && !wb_we_i) |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    property p_trimWr;
        (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == clk_ctrl_pkg::OFS_TRIM)
            |-> ##[0:1] freqTrim == $past(wb_dat_i[5:0]);
    endproperty
    property p_freqWr;
        (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == clk_ctrl_pkg::OFS_CONTROL)
            |-> ##[0:1] intFreqSel == $past(wb_dat_i[6:3]);
    endproperty
    property p_resetVal;
        $rose(arst_n) |-> intFreqSel == 4'h7 && freqTrim == 6'h00 && activeSrc == 2'h2;
    endproperty
    property p_ost;
        (activeSrc == 2'h0 && $past(activeSrc) == 2'h2 && configOscMode <= clk_ctrl_pkg::MODE_HS)
            |-> extCnt_r >= OST_COUNT;
    endproperty
    property p_stall;
        (failMonEnable && !asleep_r && stallCnt_r == STALL_MAX) |-> activeSrc != 2'h0;
    endproperty
    property p_highMin;
        $rose(sysClk) |=> sysClk;
    endproperty
    property p_lowMin;
        $fell(sysClk) |=> !sysClk;
    endproperty
    a_ackOnce:   assert property (p_ackOnce) else $error("ack not a single pulse");
    a_ackCause:  assert property (p_ackCause) else $error("ack without request");
    a_hiZero:    assert property (p_hiZero) else $error("read upper bits not zero");
    a_trimWr:    assert property (p_trimWr) else $error("trim write lost");
    a_freqWr:    assert property (p_freqWr) else $error("freq select write lost");
    a_resetVal:  assert property (p_resetVal) else $error("bad values after reset");
    a_ost:       assert property (p_ost) else $error("external used too early");
    a_stall:     assert property (p_stall) else $error("stopped clock not seen");
    a_highMin:   assert property (p_highMin) else $error("short high pulse");
    a_lowMin:    assert property (p_lowMin) else $error("short low pulse");
    c_toExt:     cover property (activeSrc == 2'h0 && $past(activeSrc) == 2'h2);
    c_fail:      cover property ($fell(activeSrc == 2'h0));
    c_write:     cover property (wb_ack_o && wb_we_i);
endmodule : two_speed_failsafe_clock_ctrl_properties

bind two_speed_failsafe_clock_ctrl two_speed_failsafe_clock_ctrl_properties #(
    .OST_COUNT(OST_COUNT), .DIV_COUNT(DIV_COUNT)) u_props (
    .clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .extOsc(extOsc),
    .configOscMode(configOscMode), .failMonEnable(failMonEnable), .sleepReq(sleepReq),
    .wakeReq(wakeReq), .sysClk(sysClk), .activeSrc(activeSrc), .intFreqSel(intFreqSel),
    .freqTrim(freqTrim));

// *** src/clk_ctrl_pkg.sv ***
// Purpose: constants for the two-speed / fail-safe clock control block
// Assumes: wishbone classic slave, 32-bit data, 8-bit registers in low bits
// Notes:   register offsets are byte addresses of aligned words
package clk_ctrl_pkg;
    // register byte offsets
    localparam logic [3:0] OFS_CONTROL = 4'h0;   // osc_control_reg
    localparam logic [3:0] OFS_STATUS  = 4'h4;   // osc_status_reg
    localparam logic [3:0] OFS_TRIM    = 4'h8;   // osc_trim_reg
    localparam logic [3:0] OFS_FLAGS   = 4'hC;   // fail flag / irq enable / misc
    // control register fields
    localparam int CTL_PLL_BIT   = 7;            // soft_pll_enable
    localparam int CTL_FREQ_LSB  = 3;            // internal_freq_select lsb
    localparam int CTL_SEL_LSB   = 0;            // sys_clk_select lsb
    localparam logic [7:0] CTL_RESET = 8'h38;    // freq select 0111, select 00
    localparam logic [7:0] CTL_WMASK = 8'hFB;    // bit 2 unimplemented
    // status register fields
    localparam int ST_T1RDY  = 7;
    localparam int ST_PLLRDY = 6;
    localparam int ST_DONE   = 5;                // startup_done_status
    localparam int ST_FRDY   = 4;
    localparam int ST_FLOCK  = 3;
    localparam int ST_MRDY   = 2;
    localparam int ST_SRDY   = 1;
    localparam int ST_FSTAB  = 0;
    // trim register
    localparam logic [7:0] TRIM_MASK = 8'h3F;    // upper two bits read zero
    // flags register fields
    localparam int FL_FAIL   = 0;                // osc_fail_flag (write 0 clears)
    localparam int FL_IRQEN  = 1;                // osc_fail_irq_enable
    localparam int FL_FSAFE  = 2;                // fail-safe in force (ro)
    localparam int FL_T1EN   = 3;                // timer1_osc_enable
    // source select encodings
    localparam logic [1:0] SEL_CONFIG = 2'h0;
    localparam logic [1:0] SEL_TIMER1 = 2'h1;
    // timing
    localparam int OST_CYCLES  = 1024;           // crystal startup count
    localparam int SAMPLE_DIV  = 64;             // slow osc divide for sample clk
    // config oscillator modes
    localparam logic [2:0] MODE_LP = 3'h0;
    localparam logic [2:0] MODE_XT = 3'h1;
    localparam logic [2:0] MODE_HS = 3'h2;
endpackage : clk_ctrl_pkg

// *** src/two_speed_failsafe_clock_ctrl.sv ***
// Purpose: clock source sequencing, fail monitor and oscillator registers
// Assumes: all oscillators arrive as asynchronous levels sampled at 200 MHz
// Notes:   edges of oscillators are detected after two-flop synchronisers
//
// Contract
// - wake runs from internal osc at freq select
// - startup timer counts 1024 external cycles
// - after timeout wait internal falling edge, set done
// - hold clock low until external falling edge
// - done bit 1 external, 0 internal
// - monitor runs only when enabled, all modes
// - sample clock is slow osc divided by 64
// - latch set ext fall, cleared sample rise
// - failure when sample half-cycle sees no low
// - failure falls back internal, flags, interrupts
// - fallback uses current internal freq select
// - fail-safe ends on reset, sleep, select write (code: not on select write; also on any ext fall in ST_EXT with select 00 and done set)
// - select change restarts timer, then external
// - flag clear ignored during fail-safe
// - ext clock or RC modes skip timer
// - monitor enable forces two-speed startup on
// - select 1x internal, 01 timer1, 00 config
// - timer1 ready reads 1 when disabled
// - locked bit means within 2 percent
// - stable bit means within half percent
// - trim six bits signed, upper bits zero
// - reset returns select field to 00
// - automatic switches leave select field alone
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
module two_speed_failsafe_clock_ctrl #(
    parameter int OST_COUNT = clk_ctrl_pkg::OST_CYCLES,   // startup count
    parameter int DIV_COUNT = clk_ctrl_pkg::SAMPLE_DIV    // sample divider
) (
    input  wire logic        clock,          // 200 MHz system clock
    input  wire logic        arst_n,         // async reset, active low
    input  wire logic        wb_cyc_i,       // wishbone cycle
    input  wire logic        wb_stb_i,       // wishbone strobe
    input  wire logic        wb_we_i,        // wishbone write
    input  wire logic [3:0]  wb_adr_i,       // byte address
    input  wire logic [3:0]  wb_sel_i,       // byte enables
    input  wire logic [31:0] wb_dat_i,       // write data
    output logic      [31:0] wb_dat_o,       // read data
    output logic             wb_ack_o,       // ack
    input  wire logic        extOsc,         // external oscillator level
    input  wire logic        internal_osc_block,         // selected internal osc level
    input  wire logic        slowOsc,        // slow internal osc level
    input  wire logic        timer1Osc,      // timer1 oscillator level
    input  wire logic [2:0]  configOscMode,  // configured oscillator mode
    input  wire logic        twoSpeedEnable, // config two-speed enable
    input  wire logic        failMonEnable,  // config monitor enable
    input  wire logic        configPllForce, // config forced pll
    input  wire logic        sleepReq,       // sleep instruction pulse
    input  wire logic        wakeReq,        // wake from sleep pulse
    input  wire logic        timer1Ready,    // timer1 osc ready level
    input  wire logic        pllReady,       // pll ready level
    input  wire logic        fastReady,      // fast osc ready
    input  wire logic        fastLocked,     // fast osc within 2 percent
    input  wire logic        fastStable,     // fast osc within 0.5 percent
    input  wire logic        midReady,       // mid osc ready
    input  wire logic        slowReady,      // slow osc ready
    output logic             sysClk,         // glitch-free system clock
    output logic [1:0]       activeSrc,      // 0 config,1 timer1,2 internal
    output logic [3:0]       intFreqSel,     // internal freq select to osc
    output logic [5:0]       freqTrim,       // trim code to osc
    output logic             pllEnable,      // pll enable to osc
    output logic             failIrq         // fail interrupt request
);
    // synchronisers: first flop only feeds second flop
    logic [1:0] extS_r, intS_r, slowS_r, t1S_r;   // stage 1/2 per source
    logic       extD_r, intD_r, slowD_r, t1D_r;   // delayed for edges
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            extS_r  <= 2'h0;
            intS_r  <= 2'h0;
            slowS_r <= 2'h0;
            t1S_r   <= 2'h0;
            extD_r  <= 1'b0;
            intD_r  <= 1'b0;
            slowD_r <= 1'b0;
            t1D_r   <= 1'b0;
        end
        else
        begin
            extS_r  <= {extS_r[0], extOsc};
            intS_r  <= {intS_r[0], internal_osc_block};
            slowS_r <= {slowS_r[0], slowOsc};
            t1S_r   <= {t1S_r[0], timer1Osc};
            extD_r  <= extS_r[1];
            intD_r  <= intS_r[1];
            slowD_r <= slowS_r[1];
            t1D_r   <= t1S_r[1];
        end
    end

    // edge strobes from synchronised levels
    logic extFall, extRise, intFall, slowRise;
    assign extFall  = extD_r & ~extS_r[1];
    assign extRise  = ~extD_r & extS_r[1];
    assign intFall  = intD_r & ~intS_r[1];
    assign slowRise = ~slowD_r & slowS_r[1];

    // registers
    logic [7:0] ctl_r;                 // osc_control_reg
    logic [7:0] trim_r;                // osc_trim_reg
    logic       failFlag_r;            // osc_fail_flag
    logic       irqEn_r;               // osc_fail_irq_enable
    logic       t1En_r;                // timer1_osc_enable
    logic       failSafe_r;            // fail-safe condition in force
    logic       done_r;                // startup_done_status

    // bus decode
    logic busReq, wrReq, selWrite;
    assign busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrReq    = busReq & wb_we_i & wb_sel_i[0];
    assign selWrite = wrReq && wb_adr_i == clk_ctrl_pkg::OFS_CONTROL &&
        wb_dat_i[1:0] != ctl_r[1:0];   // only a change of select counts

    // ack one cycle after request, dropped the next cycle
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= busReq;
    end

    // control and trim writes; select only ever changed by software
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctl_r  <= clk_ctrl_pkg::CTL_RESET;
            trim_r <= 8'h00;
            irqEn_r <= 1'b0;
            t1En_r  <= 1'b0;
        end
        else if (wrReq)
        begin
            case (wb_adr_i)
                clk_ctrl_pkg::OFS_CONTROL:
                    ctl_r <= wb_dat_i[7:0] & clk_ctrl_pkg::CTL_WMASK;
                clk_ctrl_pkg::OFS_TRIM:
                    trim_r <= wb_dat_i[7:0] & clk_ctrl_pkg::TRIM_MASK;
                clk_ctrl_pkg::OFS_FLAGS:
                begin
                    irqEn_r <= wb_dat_i[clk_ctrl_pkg::FL_IRQEN];
                    t1En_r  <= wb_dat_i[clk_ctrl_pkg::FL_T1EN];
                end
                default: ;   // status is read only
            endcase
        end
    end

    // mode decode
    logic crystalMode, twoSpeedOn;
    assign crystalMode = configOscMode == clk_ctrl_pkg::MODE_LP ||
                         configOscMode == clk_ctrl_pkg::MODE_XT ||
                         configOscMode == clk_ctrl_pkg::MODE_HS;
    assign twoSpeedOn  = twoSpeedEnable | failMonEnable;

    // startup sequencer
    typedef enum {ST_SLEEP, ST_COUNT, ST_WAIT_INT, ST_HOLD, ST_EXT} seq_e;
    seq_e seq_r;
    logic [$clog2(OST_COUNT+1)-1:0] ost_r;   // crystal_startup_timer
    logic startEvt;
    // the async reset release acts as power-on; first cycle after reset
    logic started_r;
    assign startEvt = ~started_r | wakeReq | selWrite;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            started_r <= 1'b0;
        else
            started_r <= 1'b1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seq_r  <= ST_COUNT;
            ost_r  <= '0;
            done_r <= 1'b0;
        end
        else if (sleepReq)
        begin
            seq_r  <= ST_SLEEP;   // sleep aborts startup and clears done
            done_r <= 1'b0;
            ost_r  <= '0;
        end
        else if (startEvt)
        begin
            ost_r  <= '0;
            done_r <= 1'b0;
            seq_r  <= crystalMode ? ST_COUNT : ST_HOLD;
        end
        else
        begin
            case (seq_r)
                ST_SLEEP: seq_r <= ST_SLEEP;
                ST_COUNT:
                    if (extRise)
                    begin
                        if (ost_r == ($bits(ost_r))'(OST_COUNT - 1))
                            seq_r <= ST_WAIT_INT;
                        ost_r <= ost_r + 1'b1;
                    end
                ST_WAIT_INT:
                    if (intFall)
                    begin
                        done_r <= 1'b1;
                        seq_r  <= ST_HOLD;
                    end
                ST_HOLD:
                    if (extFall)
                    begin
                        done_r <= 1'b1;
                        seq_r  <= ST_EXT;
                    end
                ST_EXT: seq_r <= ST_EXT;
                default: seq_r <= ST_COUNT;
            endcase
        end
    end
    // without two-speed, want picks the config source during the count, not the internal clock
    logic ostRunning;
    assign ostRunning = seq_r == ST_COUNT || seq_r == ST_WAIT_INT;

    // sample clock: slow osc divided by 64 (toggle each 32 rising edges)
    logic [$clog2(DIV_COUNT)-1:0] div_r;
    logic sample_r, sampleD_r;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_r     <= '0;
            sample_r  <= 1'b0;
            sampleD_r <= 1'b0;
        end
        else
        begin
            sampleD_r <= sample_r;
            if (slowRise)
            begin
                div_r <= div_r + 1'b1;
                if (div_r == ($bits(div_r))'(DIV_COUNT/2 - 1) ||
                    div_r == ($bits(div_r))'(DIV_COUNT - 1))
                    sample_r <= ~sample_r;
            end
        end
    end
    logic sampleRise, sampleFall;
    assign sampleRise = sample_r & ~sampleD_r;
    assign sampleFall = ~sample_r & sampleD_r;

    // detector latch and failure decision
    logic seen_r, failDet;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            seen_r <= 1'b0;
        else if (extFall)
            seen_r <= 1'b1;
        else if (sampleRise)
            seen_r <= 1'b0;
    end
    // latch still clear at the sample falling edge: a whole high half passed
    assign failDet = failMonEnable & sampleFall & ~seen_r & ~extFall
                   & ~ostRunning & seq_r != ST_SLEEP;

    // fail-safe condition
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            failSafe_r <= 1'b0;
        else if (failDet)
            failSafe_r <= 1'b1;
        else if (sleepReq || (seq_r == ST_EXT && !selWrite && ctl_r[1:0] ==
                 clk_ctrl_pkg::SEL_CONFIG && done_r && extFall))
            failSafe_r <= 1'b0;
    end

    // fail flag: set wins over clear, clear blocked while fail-safe held
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            failFlag_r <= 1'b0;
        else if (failDet)
            failFlag_r <= 1'b1;
        else if (wrReq && wb_adr_i == clk_ctrl_pkg::OFS_FLAGS &&
                 !wb_dat_i[clk_ctrl_pkg::FL_FAIL] && !failSafe_r)
            failFlag_r <= 1'b0;
    end
    assign failIrq = failFlag_r & irqEn_r;

    // source choice, from select field and automatic state
    logic [1:0] want;
    always_comb
    begin
        if (ctl_r[1])
            want = 2'h2;
        else if (ctl_r[1:0] == clk_ctrl_pkg::SEL_TIMER1)
            want = 2'h1;
        else if (failSafe_r || (twoSpeedOn && seq_r != ST_EXT))
            want = 2'h2;
        else
            want = 2'h0;
    end

    // glitch-free mux: drop old source on its low, pick new on its low
    logic [1:0] src_r;
    logic       gate_r;                // system clock gated low
    logic       curLevel, newLow, curLow;
    function automatic logic lvl(input logic [1:0] s, input logic e,
                                 input logic i, input logic t);
        lvl = (s == 2'h0) ? e : (s == 2'h1) ? t : i;
    endfunction : lvl
    assign curLevel = lvl(src_r, extS_r[1], intS_r[1], t1S_r[1]);
    assign curLow   = ~curLevel;
    assign newLow   = ~lvl(want, extS_r[1], intS_r[1], t1S_r[1]);
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            src_r  <= 2'h2;
            gate_r <= 1'b0;
            sysClk <= 1'b0;
        end
        else
        begin
            if (want != src_r && !gate_r && curLow)
                gate_r <= 1'b1;
            else if (gate_r && newLow)
            begin
                src_r  <= want;
                gate_r <= 1'b0;
            end
            sysClk <= gate_r ? 1'b0 : curLevel;
        end
    end
    assign activeSrc = src_r;

    // outputs to oscillators
    assign intFreqSel = ctl_r[6:3];
    assign freqTrim   = trim_r[5:0];
    assign pllEnable  = ctl_r[clk_ctrl_pkg::CTL_PLL_BIT] | configPllForce;

    // status composition
    logic [7:0] status;
    always_comb
    begin
        status = 8'h00;
        status[clk_ctrl_pkg::ST_T1RDY]  = ~t1En_r | timer1Ready;
        status[clk_ctrl_pkg::ST_PLLRDY] = pllReady;
        status[clk_ctrl_pkg::ST_DONE]   = done_r & ~failSafe_r;
        status[clk_ctrl_pkg::ST_FRDY]   = fastReady;
        status[clk_ctrl_pkg::ST_FLOCK]  = fastLocked;
        status[clk_ctrl_pkg::ST_MRDY]   = midReady;
        status[clk_ctrl_pkg::ST_SRDY]   = slowReady;
        status[clk_ctrl_pkg::ST_FSTAB]  = fastStable;
    end

    // read data registered with ack; unmapped reads return zero
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            wb_dat_o <= 32'h0000_0000;
        else if (busReq && !wb_we_i)
        begin
            case (wb_adr_i)
                clk_ctrl_pkg::OFS_CONTROL: wb_dat_o <= {24'h000000, ctl_r};
                clk_ctrl_pkg::OFS_STATUS:  wb_dat_o <= {24'h000000, status};
                clk_ctrl_pkg::OFS_TRIM:    wb_dat_o <= {24'h000000, trim_r};
                clk_ctrl_pkg::OFS_FLAGS:   wb_dat_o <= {28'h0000000, t1En_r,
                                               failSafe_r, irqEn_r, failFlag_r};
                default:                   wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule : two_speed_failsafe_clock_ctrl
